// ==== design/tcp_pkg.sv ====
// Package for the trim cell profile control block.
// Assumes a single 25 MHz system clock shared by both ends.
package tcp_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_CHANNELS = 4;
  localparam int NUM_PROFILES = 3;
  localparam int DAC_WIDTH = 8;
  localparam int SETPOINT_WIDTH = 12;
  localparam int SELECT_WIDTH = 2;
  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [7:0] DAC_BIPOLAR_ZERO = 8'h80;
  localparam logic [7:0] DAC_MAX = 8'hff;
  localparam logic [7:0] DAC_MIN = 8'h00;
  localparam logic [1:0] PROFILE_0 = 2'h0;
  localparam logic [1:0] PROFILE_1 = 2'h1;
  localparam logic [1:0] PROFILE_2 = 2'h2;
  // ----------------------------------------
  // Update interval
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int UPDATE_INTERVAL_US = 860;
  localparam int UPDATE_CYCLES = (UPDATE_INTERVAL_US * 1000) / CLK_PERIOD_NS;
  // ----------------------------------------
  // Control register offsets (controller side)
  // ----------------------------------------
  localparam logic [3:0] REG_PROFILE_SELECT = 4'h0;
  localparam logic [3:0] REG_LOOP_ENABLE = 4'h1;
  localparam logic [3:0] REG_OUTPUT_ENABLE = 4'h2;
  localparam logic [3:0] REG_DAC_BASE = 4'h4;
  localparam logic [3:0] REG_SETPOINT_BASE = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;
endpackage : tcp_pkg

// ==== design/tcp_link_if.sv ====
// Sense-control link between user logic and the trim cells.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface tcp_link_if;
  logic [3:0] trim_loop_enable;
  logic [3:0] profile_select_low;
  logic [3:0] profile_select_high;
  logic [3:0] trim_output_enable;
  logic [31:0] dac_code;
  logic [3:0] dac_drive;
  modport device (
    input trim_loop_enable, profile_select_low, profile_select_high, trim_output_enable,
    output dac_code, dac_drive
  );
  modport user (
    output trim_loop_enable, profile_select_low, profile_select_high, trim_output_enable,
    input dac_code, dac_drive
  );
endinterface : tcp_link_if

// ==== design/tcp_trim_device.sv ====
// What this block does
// - Four independent trim channels, three levels each
// - Drive 8-bit DAC; closed-loop default, manual optional
// - Manual loads selected code straight into DAC
// - Manual keeps three 8-bit profile codes
// - Manual reloads DAC when selects change
// - Host overwrites profile 0 code unless protected
// - Closed-loop keeps three 12-bit setpoints
// - Closed-loop copies setpoint when selects change
// - Host overwrites profile 0 setpoint unless protected
// - Compare setpoint with monitor reading, adjust DAC
// - Adjust only while loop enable is one
// - Two selects per channel, chosen independently
// - Output active only while output enable one
// - Output enable zero clears dac_drive; dac_code stays driven
// - Step one by sign and polarity; equal holds
// - Loop off holds; reset starts at 80h
// - Manual reset loads profile 0, outputs off
//
// Trim cell device end: four channels of profile and closed-loop trim logic.
// Assumes monitor readings and host writes are synchronous to CLK_SYS.
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module tcp_trim_device #(
  parameter int UPDATE_CYCLES = tcp_pkg::UPDATE_CYCLES,
  parameter logic [3:0] MANUAL_MODE = 4'h0,
  parameter logic [3:0] POLARITY_INVERT = 4'h0,
  parameter logic WRITE_PROTECT = 1'b0,
  parameter logic [31:0] PROFILE_CODE_0 = 32'h80808080,
  parameter logic [31:0] PROFILE_CODE_1 = 32'h90909090,
  parameter logic [31:0] PROFILE_CODE_2 = 32'h70707070,
  parameter logic [47:0] PROFILE_SETPOINT_0 = 48'h800800800800,
  parameter logic [47:0] PROFILE_SETPOINT_1 = 48'h900900900900,
  parameter logic [47:0] PROFILE_SETPOINT_2 = 48'h700700700700
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic CLK_EN,
  tcp_link_if.device LINK,
  input wire logic [47:0] MONITOR_READING,
  input wire logic HOST_WRITE,
  input wire logic [1:0] HOST_CHANNEL,
  input wire logic HOST_IS_SETPOINT,
  input wire logic [11:0] HOST_DATA,
  output logic HOST_REJECTED
);
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (UPDATE_CYCLES < 1) begin : g_bad_update
    $error("UPDATE_CYCLES must be at least one");
  end
  if (tcp_pkg::NUM_CHANNELS != 4) begin : g_bad_channels
    $error("Link widths serve exactly four channels");
  end
  if (tcp_pkg::DAC_WIDTH != 8) begin : g_bad_dac
    $error("DAC register width must be eight bits");
  end
  if (tcp_pkg::SETPOINT_WIDTH != 12) begin : g_bad_setpoint
    $error("Setpoint width must be twelve bits");
  end
  if (tcp_pkg::SELECT_WIDTH != 2) begin : g_bad_select
    $error("Select decode serves exactly two select lines");
  end
  if (tcp_pkg::NUM_PROFILES != 3) begin : g_bad_profiles
    $error("Select decode serves exactly three profiles");
  end
  if ($bits(PROFILE_CODE_0) != tcp_pkg::NUM_CHANNELS * tcp_pkg::DAC_WIDTH) begin : g_bad_code_list
    $error("Profile code lists must hold one code per channel");
  end
  if ($bits(PROFILE_SETPOINT_0) != tcp_pkg::NUM_CHANNELS * tcp_pkg::SETPOINT_WIDTH) begin : g_bad_setpoint_list
    $error("Profile setpoint lists must hold one setpoint per channel");
  end

  // ----------------------------------------
  // Shared update tick
  // ----------------------------------------
  logic [31:0] tick_count;
  wire update_tick = (tick_count == 32'(UPDATE_CYCLES - 1));
  wire [31:0] next_tick_count = update_tick ? 32'h0 : tick_count + 32'h1;

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      tick_count <= 32'h0;
    end else if (CLK_EN) begin
      tick_count <= next_tick_count;
    end
  end

  // ----------------------------------------
  // Host write protection
  // ----------------------------------------
  wire host_blocked = HOST_WRITE & WRITE_PROTECT;

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      HOST_REJECTED <= 1'b0;
    end else if (CLK_EN) begin
      HOST_REJECTED <= host_blocked;
    end
  end

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < tcp_pkg::NUM_CHANNELS; ch++) begin : g_chan
      logic [7:0] code0;
      logic [11:0] setpoint0;
      logic [7:0] dac;
      logic [11:0] work_setpoint;
      logic [1:0] select_prev;
      logic drive;
      logic started;
      wire [1:0] select_now = {LINK.profile_select_high[ch], LINK.profile_select_low[ch]};
      wire [1:0] index = (select_now == 2'h3) ? tcp_pkg::PROFILE_2 : select_now;
      wire [7:0] code_pick = (index == tcp_pkg::PROFILE_0) ? code0 :
        (index == tcp_pkg::PROFILE_1) ? PROFILE_CODE_1[ch*8 +: 8] : PROFILE_CODE_2[ch*8 +: 8];
      wire [11:0] setpoint_pick = (index == tcp_pkg::PROFILE_0) ? setpoint0 :
        (index == tcp_pkg::PROFILE_1) ? PROFILE_SETPOINT_1[ch*12 +: 12] : PROFILE_SETPOINT_2[ch*12 +: 12];
      wire select_changed = started & (select_now != select_prev);
      wire [11:0] reading = MONITOR_READING[ch*12 +: 12];
      wire above = work_setpoint > reading;
      wire below = work_setpoint < reading;
      wire step_up = POLARITY_INVERT[ch] ? below : above;
      wire step_down = POLARITY_INVERT[ch] ? above : below;
      wire host_here = HOST_WRITE & ~WRITE_PROTECT & (HOST_CHANNEL == 2'(ch));
      wire loop_step = LINK.trim_loop_enable[ch] & update_tick;
      // ----------------------------------------
      // Next values
      // ----------------------------------------
      wire [7:0] next_loop_dac = (step_up && dac != tcp_pkg::DAC_MAX) ? dac + 8'h1 :
        (step_down && dac != tcp_pkg::DAC_MIN) ? dac - 8'h1 : dac;
      wire manual = MANUAL_MODE[ch];
      wire host_code = host_here & ~HOST_IS_SETPOINT;
      wire host_setpoint = host_here & HOST_IS_SETPOINT;
      wire [7:0] next_code0 = host_code ? HOST_DATA[7:0] : code0;
      wire [11:0] next_setpoint0 = host_setpoint ? HOST_DATA : setpoint0;
      wire [11:0] next_work_setpoint = (!manual && select_changed) ? setpoint_pick : work_setpoint;
      wire [7:0] next_manual_dac = select_changed ? code_pick : dac;
      wire [7:0] next_auto_dac = loop_step ? next_loop_dac : dac;
      wire [7:0] next_dac = manual ? next_manual_dac : next_auto_dac;

      // ----------------------------------------
      // Profile 0 store
      // ----------------------------------------
      always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
          code0 <= PROFILE_CODE_0[ch*8 +: 8];
          setpoint0 <= PROFILE_SETPOINT_0[ch*12 +: 12];
        end else if (CLK_EN) begin
          code0 <= next_code0;
          setpoint0 <= next_setpoint0;
        end
      end

      // ----------------------------------------
      // Select tracking
      // ----------------------------------------
      always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
          select_prev <= 2'h0;
          started <= 1'b0;
        end else if (CLK_EN) begin
          select_prev <= select_now;
          started <= 1'b1;
        end
      end

      // ----------------------------------------
      // Output drive
      // ----------------------------------------
      always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
          drive <= 1'b0;
        end else if (CLK_EN) begin
          drive <= LINK.trim_output_enable[ch];
        end
      end

      // ----------------------------------------
      // Working setpoint
      // ----------------------------------------
      always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
          work_setpoint <= PROFILE_SETPOINT_0[ch*12 +: 12];
        end else if (CLK_EN) begin
          work_setpoint <= next_work_setpoint;
        end
      end

      // ----------------------------------------
      // DAC register
      // ----------------------------------------
      always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
          dac <= MANUAL_MODE[ch] ? PROFILE_CODE_0[ch*8 +: 8] : tcp_pkg::DAC_BIPOLAR_ZERO;
        end else if (CLK_EN) begin
          dac <= next_dac;
        end
      end

      // ----------------------------------------
      // Link outputs
      // ----------------------------------------
      assign LINK.dac_code[ch*8 +: 8] = dac;
      assign LINK.dac_drive[ch] = drive;
    end
  endgenerate
endmodule : tcp_trim_device

// ==== design/tcp_user_ctrl.sv ====
// User-logic end: registers drive the link controls and show trim state.
// Assumes a plain one-cycle strobe register port on CLK_SYS.
`timescale 1ns/10ps
module tcp_user_ctrl (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic CLK_EN,
  tcp_link_if.user LINK,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA
);
  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [7:0] select_reg;
  logic [3:0] loop_reg;
  logic [3:0] oe_reg;
  wire [7:0] code_sel = LINK.dac_code[{ADDR[1:0], 3'h0} +: 8];
  wire is_dac = (ADDR[3:2] == tcp_pkg::REG_DAC_BASE[3:2]);
  wire [31:0] read_mux =
    (ADDR == tcp_pkg::REG_PROFILE_SELECT) ? {24'h0, select_reg} :
    (ADDR == tcp_pkg::REG_LOOP_ENABLE) ? {28'h0, loop_reg} :
    (ADDR == tcp_pkg::REG_OUTPUT_ENABLE) ? {28'h0, oe_reg} :
    is_dac ? {24'h0, code_sel} :
    (ADDR == tcp_pkg::REG_STATUS) ? {28'h0, LINK.dac_drive} : 32'h0;

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      select_reg <= 8'h0;
      loop_reg <= 4'h0;
      oe_reg <= 4'h0;
      RDATA <= 32'h0;
    end else if (CLK_EN) begin
      if (WR && ADDR == tcp_pkg::REG_PROFILE_SELECT) select_reg <= WDATA[7:0];
      if (WR && ADDR == tcp_pkg::REG_LOOP_ENABLE) loop_reg <= WDATA[3:0];
      if (WR && ADDR == tcp_pkg::REG_OUTPUT_ENABLE) oe_reg <= WDATA[3:0];
      RDATA <= RD ? read_mux : 32'h0;
    end
  end

  // ----------------------------------------
  // Link drive: select bits 2c = low, 2c+1 = high
  // ----------------------------------------
  genvar c;
  generate
    for (c = 0; c < 4; c++) begin : g_sel
      assign LINK.profile_select_low[c] = select_reg[2*c];
      assign LINK.profile_select_high[c] = select_reg[2*c+1];
    end
  endgenerate
  assign LINK.trim_loop_enable = loop_reg;
  assign LINK.trim_output_enable = oe_reg;
endmodule : tcp_user_ctrl

// ==== verif/tcp_properties.sv ====
// Checker watching the link between the user end and the device end.
// Assumes channels 0-1 manual, 2-3 closed loop, default profile codes.
`timescale 1ns/10ps
module tcp_properties (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic [3:0] trim_loop_enable,
  input wire logic [3:0] profile_select_low,
  input wire logic [3:0] profile_select_high,
  input wire logic [3:0] trim_output_enable,
  input wire logic [31:0] dac_code,
  input wire logic [3:0] dac_drive
);
  // ----------------------------------------
  // Link assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  sequence loop_off_s;
    !trim_loop_enable[2] [*3];
  endsequence
  property load_p(int c, logic hi, logic [7:0] code);
    $changed({profile_select_high[c], profile_select_low[c]}) && profile_select_high[c] == hi
      && (hi || profile_select_low[c]) |=> dac_code[8*c +: 8] == code;
  endproperty
  property hold_p(int c);
    !$changed({profile_select_high[c], profile_select_low[c]}) |=> $stable(dac_code[8*c +: 8]);
  endproperty
  oe_follow_a: assert property (dac_drive == $past(trim_output_enable)) else $error("drive not following enable");
  load_high_a: assert property (load_p(0, 1'b1, 8'h70)) else $error("profile 2 code not loaded");
  load_one_a: assert property (load_p(1, 1'b0, 8'h90)) else $error("profile 1 code not loaded");
  code_hold_a: assert property (hold_p(0)) else $error("manual code moved without select change");
  chan_indep_a: assert property (hold_p(1)) else $error("channel 1 code moved on its own");
  loop_step_a: assert property ($changed(dac_code[23:16]) |->
    8'(dac_code[23:16] - $past(dac_code[23:16])) inside {8'h01, 8'hff}) else $error("loop step not one");
  loop_hold_a: assert property (loop_off_s |-> $stable(dac_code[23:16])) else $error("loop off but code moved");
  reset_state_a: assert property ($fell(RESET) |-> dac_code == 32'h80808080 && dac_drive == 4'h0)
    else $error("wrong state after reset");
endmodule : tcp_properties

// ==== verif/tcp_tb.sv ====
// Self-checking testbench for the user end and device end of the trim link.
// Assumes the two ends meet over tcp_link_if on one clock.
`timescale 1ns/10ps
module trim_cell_profile_control_tb;
  logic clk_sys, reset, wr_s, rd_s, host_write, host_is_setpoint, host_rejected;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, v, r;
  logic [1:0] host_channel, s0, s1;
  logic [11:0] host_data;
  logic [47:0] monitor;
  logic [7:0] code0;
  int n_errors, n_tests, seed;
  // ----------------------------------------
  // Design, link and checker
  // ----------------------------------------
  tcp_link_if link ();
  tcp_trim_device #(.UPDATE_CYCLES(8), .MANUAL_MODE(4'h3)) tcp_trim_device_inst (.CLK_SYS(clk_sys), .RESET(reset),
    .CLK_EN(1'b1), .LINK(link), .MONITOR_READING(monitor), .HOST_WRITE(host_write), .HOST_CHANNEL(host_channel),
    .HOST_IS_SETPOINT(host_is_setpoint), .HOST_DATA(host_data), .HOST_REJECTED(host_rejected));
  tcp_user_ctrl tcp_user_ctrl_inst (.CLK_SYS(clk_sys), .RESET(reset), .CLK_EN(1'b1), .LINK(link), .ADDR(addr),
    .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata));
  tcp_properties tcp_properties_inst (.CLK_SYS(clk_sys), .RESET(reset), .trim_loop_enable(link.trim_loop_enable),
    .profile_select_low(link.profile_select_low), .profile_select_high(link.profile_select_high),
    .trim_output_enable(link.trim_output_enable), .dac_code(link.dac_code), .dac_drive(link.dac_drive));
  function automatic logic [7:0] exp_code(input logic [1:0] s, input logic host_ch);
    return (s == 2'h0) ? (host_ch ? code0 : 8'h80) : ((s == 2'h1) ? 8'h90 : 8'h70);
  endfunction : exp_code
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask : rd
  task automatic host(input logic sp, input logic [1:0] ch, input logic [11:0] d);
    @(posedge clk_sys);
    host_write <= 1'b1;
    host_is_setpoint <= sp;
    host_channel <= ch;
    host_data <= d;
    @(posedge clk_sys);
    host_write <= 1'b0;
    #1 chk("rejected", 32'h0, {31'h0, host_rejected});
  endtask : host
  task automatic results;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    {seed, n_errors, n_tests} = {32'd10013, 64'h0};
    {reset, wr_s, rd_s, host_write, host_is_setpoint} = 5'h10;
    {addr, wdata, host_channel, host_data} = 50'h0;
    code0 = 8'h80;
    monitor = {4{12'h700}};
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    rd(4'hc); chk("status", 32'h0, v);
    for (int c = 0; c < 4; c++) begin
      rd(4'h4 + c[3:0]); chk("reset code", 32'h80, v);
    end
    for (int i = 0; i < 12; i++) begin
      s0 = (i < 4) ? i[1:0] : 2'($random(seed));
      s1 = 2'($random(seed));
      wr(4'h0, {28'h0, s1, s0});
      repeat (3) @(posedge clk_sys);
      rd(4'h4); chk("ch0 code", {24'h0, exp_code(s0, 1'b1)}, v);
      rd(4'h5); chk("ch1 code", {24'h0, exp_code(s1, 1'b0)}, v);
      if (i == 3) begin
        host(1'b0, 2'h0, 12'h03c);
        code0 = 8'h3c;
      end
    end
    for (int k = 0; k < 3; k++) begin
      r = (k == 0) ? 32'hf : $random(seed);
      wr(4'h2, {28'h0, r[3:0]});
      repeat (2) @(posedge clk_sys);
      rd(4'hc); chk("drive", {28'h0, r[3:0]}, v);
    end
    wr(4'h3, 32'hff);
    rd(4'h3); chk("unmapped", 32'h0, v);
    wr(4'h1, 32'h4);
    repeat (40) @(posedge clk_sys);
    rd(4'h6); chk("loop up", 32'h1, {31'h0, v[7:0] > 8'h80 && v[7:0] < 8'h88});
    wr(4'h1, 32'h0);
    repeat (3) @(posedge clk_sys);
    rd(4'h6);
    r = v;
    monitor[35:24] <= 12'h800;
    repeat (30) @(posedge clk_sys);
    rd(4'h6); chk("loop off", r, v);
    wr(4'h1, 32'h4);
    repeat (30) @(posedge clk_sys);
    rd(4'h6); chk("loop equal", r, v);
    host(1'b1, 2'h2, 12'h600);
    wr(4'h0, 32'h10);
    wr(4'h0, 32'h0);
    repeat (40) @(posedge clk_sys);
    rd(4'h6); chk("loop down", 32'h1, {31'h0, v[7:0] < r[7:0]});
    rd(4'h7); chk("ch3 idle", 32'h80, v);
    results();
  end
endmodule : trim_cell_profile_control_tb
